// ===== rtl/hbsi_top.sv
// file: host bus strap interface, decode, latches, arbitration, timeout
// Operation
// - match address bits 2..7 or 2..15 against strapped base bits
// - bits 8 and up join the match only with 16-bit strap
// - four write-only byte ports on a four-byte base, default A8 hex
// - host interrupt goes on one of eight lines, line five by default
// - bus hold keeps ownership until local processor waits or idles
// - without hold, release bus after current cycle when requested
// - request either driven to bus or disconnected, arbiter input low
// - high and mid latches take the full low data byte on write
// - each low latch bit takes data, zero or one, one by default
// - master with clock option sources bus clocks from transmit clock
// - local ram access gets zero or one wait state, one default
// - with timeout enabled, missing ready is generated after timeout
// - timeout interrupt raises local input when enabled, else low
// - socket pairs are rom or ram; sizes 64/64, 128/64, 128/128
`timescale 1ns/10ps
module hbsi_top
  import hbsi_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // straps
  input wire hbsi_strap_s strap,
  // host bus slave side
  input wire hbsi_host_s host,
  // arbitration
  input wire logic bus_req,
  input wire logic cbrq_in_n,
  input wire logic cycle_done,
  input wire logic cpu_wait_idle,
  input wire logic bpro_arb_n,
  // local processor
  input wire logic host_irq_req,
  input wire logic cycle_start,
  input wire logic ext_ready,
  input wire logic ram_access,
  input wire logic [17:0] local_adr,
  input wire logic tx_clk,
  // outputs
  output logic [7:0] host_command_high,
  output logic [7:0] host_command_mid,
  output logic [7:0] host_command_low,
  output logic [2:0] flag_pulse,
  output logic [7:0] bus_int,
  output logic bus_owned,
  output logic cbrq_out_n,
  output logic cbrq_arb_n,
  output logic bpro_out_n,
  output logic bclk_out,
  output logic cclk_out_n,
  output logic local_ready,
  output logic tmo_irq,
  output logic rom_sel,
  output logic ram_sel
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] mid;
    logic [7:0] low;
    logic [2:0] flag;
    logic [7:0] bint;
    hbsi_arb_e arb;
    logic own;
    logic cbrq_o;
    logic cbrq_a;
    logic bpro;
    logic bclk;
    logic cclk;
    logic [3:0] tmo_cnt;
    logic tmo_armed;
    logic wait_done;
    logic rdy;
    logic tirq;
    logic rom;
    logic ram;
  } hbsi_state_s;

  hbsi_state_s st_ff;
  hbsi_state_s nxt_st;
  logic [7:0] low_val;
  logic [15:0] mask;
  logic hit;
  logic tmo_fire;
  logic is_rom;
  // every check below runs on clk and stands idle while reset is high
  default clocking cb_chk @(posedge clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // low latch sources, one selector per bit
  // ---------------------------------------------------------------
  for (genvar gi = 0; gi < 8; gi++)
  begin : g_low
    hbsi_low_bit u_bit (
      .src(strap.low_src[2*gi +: 2]),
      .din(host.dat[gi]),
      .dout(low_val[gi])
    );
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // upper byte masked out in 8-bit mode; straps read live
  always_comb
  begin
    mask = 16'h00FC;
    if (strap.addr16)
      mask = 16'hFFFC;
    hit = (host.adr & mask) == (strap.base & mask) && host.iowc;
  end

  // local memory: bank of 32K words picked by top address bits
  always_comb
  begin
    case (local_adr[17:15])
      3'h7: is_rom = 1'b1;
      3'h0: is_rom = 1'b0;
      3'h6: is_rom = !strap.pair_ram[3];
      3'h5: is_rom = !strap.pair_ram[2];
      3'h4: is_rom = !strap.pair_ram[1];
      3'h3: is_rom = !strap.pair_ram[0];
      default: is_rom = (strap.mem_size == 2'h1);
    endcase
  end

  assign tmo_fire = st_ff.tmo_armed && strap.tmo_en && !ext_ready &&
                    (st_ff.tmo_cnt == HBSI_TIMEOUT_CNT);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.flag = 3'h0;
    // command latches, host writes only
    if (hit)
    begin
      case (host.adr[1:0])
        HBSI_OFS_HIGH: nxt_st.high = host.dat;
        HBSI_OFS_MID: nxt_st.mid = host.dat;
        HBSI_OFS_LOW: nxt_st.low = low_val;
        HBSI_OFS_FLAG: nxt_st.flag = host.dat[2:0];
        default: nxt_st.flag = 3'h0;
      endcase
    end
    // host interrupt on one selected line
    nxt_st.bint = 8'h00;
    nxt_st.bint[strap.int_sel] = host_irq_req;
    // arbitration
    case (st_ff.arb)
      HBSI_IDLE:
        if (bus_req)
          nxt_st.arb = HBSI_OWN;
      HBSI_OWN:
        if (strap.bus_hold ? cpu_wait_idle
            : (!cbrq_in_n && cycle_done))
          nxt_st.arb = HBSI_REL;
      HBSI_REL:
        nxt_st.arb = HBSI_IDLE;
      default:
        nxt_st.arb = HBSI_IDLE;
    endcase
    nxt_st.own = nxt_st.arb == HBSI_OWN;
    nxt_st.cbrq_o = strap.req_to_bus ?
                    !(bus_req && st_ff.arb != HBSI_OWN) : 1'b1;
    nxt_st.cbrq_a = strap.req_to_bus ? cbrq_in_n : 1'b0;
    nxt_st.bpro = bpro_arb_n;
    // bus clocks while master, sampled copy of transmit clock
    nxt_st.bclk = strap.clk_opt && st_ff.arb == HBSI_OWN && tx_clk;
    nxt_st.cclk = !nxt_st.bclk;
    // ready: wait state, then timeout
    nxt_st.rdy = 1'b0;
    nxt_st.tirq = 1'b0;
    if (cycle_start)
    begin
      nxt_st.tmo_armed = 1'b1;
      nxt_st.tmo_cnt = 4'h1;
      nxt_st.wait_done = 1'b0;
    end
    else if (st_ff.tmo_armed)
    begin
      nxt_st.tmo_cnt = st_ff.tmo_cnt + 4'h1;
      if (ram_access && (strap.zero_wait || st_ff.wait_done))
      begin
        nxt_st.rdy = 1'b1;
        nxt_st.tmo_armed = 1'b0;
      end
      else if (ram_access)
        nxt_st.wait_done = 1'b1;
      else if (ext_ready)
      begin
        nxt_st.rdy = 1'b1;
        nxt_st.tmo_armed = 1'b0;
      end
      else if (tmo_fire)
      begin
        nxt_st.rdy = 1'b1;
        nxt_st.tirq = strap.tmo_int_en;
        nxt_st.tmo_armed = 1'b0;
      end
    end
    nxt_st.rom = is_rom;
    nxt_st.ram = !is_rom;
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff <= '0;
      st_ff.cbrq_o <= 1'b1;
      st_ff.bpro <= 1'b1;
      st_ff.cclk <= 1'b1;
      st_ff.high <= HBSI_LATCH_RESET;
    end
    else
      st_ff <= nxt_st;
  end

  // outputs straight from flops
  assign host_command_high = st_ff.high;
  assign host_command_mid = st_ff.mid;
  assign host_command_low = st_ff.low;
  assign flag_pulse = st_ff.flag;
  assign bus_int = st_ff.bint;
  assign bus_owned = st_ff.own;
  assign cbrq_out_n = st_ff.cbrq_o;
  assign cbrq_arb_n = st_ff.cbrq_a;
  assign bpro_out_n = st_ff.bpro;
  assign bclk_out = st_ff.bclk;
  assign cclk_out_n = st_ff.cclk;
  assign local_ready = st_ff.rdy;
  assign tmo_irq = st_ff.tirq;
  assign rom_sel = st_ff.rom;
  assign ram_sel = st_ff.ram;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_mid_load;
    hit && host.adr[1:0] == HBSI_OFS_MID |=>
      host_command_mid == $past(host.dat);
  endproperty
  a_mid_load: assert property (p_mid_load) else $error("mid missed");
  property p_no_load_wo_write;
    !host.iowc |=> $stable(host_command_high) && $stable(host_command_low);
  endproperty
  a_no_load_wo_write: assert property (p_no_load_wo_write)
    else $error("load without write");
  property p_one_line;
    $onehot0(bus_int);
  endproperty
  a_one_line: assert property (p_one_line) else $error("two lines");
  property p_line_sel;
    host_irq_req |=> bus_int[$past(strap.int_sel)];
  endproperty
  a_line_sel: assert property (p_line_sel) else $error("wrong line");
  property p_release;
    bus_owned && !strap.bus_hold && !cbrq_in_n && cycle_done |=> !bus_owned;
  endproperty
  a_release: assert property (p_release) else $error("no release");
  property p_hold;
    bus_owned && strap.bus_hold && !cpu_wait_idle |=> bus_owned;
  endproperty
  a_hold: assert property (p_hold) else $error("bus dropped in hold");
  property p_arb_gnd;
    !strap.req_to_bus |=> !cbrq_arb_n && cbrq_out_n;
  endproperty
  a_arb_gnd: assert property (p_arb_gnd) else $error("not cut");
  property p_tmo_int;
    tmo_irq |-> local_ready && $past(strap.tmo_int_en);
  endproperty
  a_tmo_int: assert property (p_tmo_int) else $error("stray irq");
  sequence s_ram_start;
    cycle_start && !strap.zero_wait ##1 ram_access;
  endsequence
  property p_one_wait;
    s_ram_start |=> !local_ready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("no wait");
  property p_clk_inv;
    cclk_out_n == !bclk_out;
  endproperty
  a_clk_inv: assert property (p_clk_inv) else $error("bad cclk");

endmodule : hbsi_top

// ===== rtl/hbsi_pkg.sv
// package: constants and carrier types for the host bus strap interface
package hbsi_pkg;

  // ---------------------------------------------------------------
  // decode and strap defaults
  // ---------------------------------------------------------------
  localparam logic [15:0] HBSI_BASE_DEFAULT = 16'h00A8;
  localparam logic [2:0] HBSI_INT_SEL_DEFAULT = 3'h5;
  localparam int HBSI_ADDR_LO_BIT = 2;
  localparam int HBSI_ADDR_HI8_BIT = 7;
  localparam int HBSI_ADDR_HI16_BIT = 15;

  // port offsets inside the four byte window
  localparam logic [1:0] HBSI_OFS_FLAG = 2'h0;
  localparam logic [1:0] HBSI_OFS_LOW = 2'h1;
  localparam logic [1:0] HBSI_OFS_MID = 2'h2;
  localparam logic [1:0] HBSI_OFS_HIGH = 2'h3;

  // latch reset values
  localparam logic [7:0] HBSI_LATCH_RESET = 8'h00;

  // low latch per-bit source select
  localparam logic [1:0] HBSI_SRC_ONE = 2'h0;
  localparam logic [1:0] HBSI_SRC_ZERO = 2'h1;
  localparam logic [1:0] HBSI_SRC_DATA = 2'h2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int HBSI_CLK_PERIOD_NS = 25;
  localparam int HBSI_TIMEOUT_NS = 10;
  // longest time rounds down, but never below one cycle
  localparam int HBSI_TIMEOUT_CYC =
    (HBSI_TIMEOUT_NS / HBSI_CLK_PERIOD_NS) < 1 ? 1 :
    (HBSI_TIMEOUT_NS / HBSI_CLK_PERIOD_NS);
  localparam logic [3:0] HBSI_TIMEOUT_CNT = 4'(HBSI_TIMEOUT_CYC);

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] base;      // per-bit high/low base value
    logic addr16;           // 16-bit addressing fitted
    logic [2:0] int_sel;    // host interrupt line select
    logic bus_hold;         // hold bus until local wait/idle
    logic req_to_bus;       // drive request onto bus
    logic clk_opt;          // bus clocks from transmit clock
    logic zero_wait;        // zero wait state on local ram
    logic tmo_en;           // timeout ready enable
    logic tmo_int_en;       // timeout interrupt enable
    logic [15:0] low_src;   // two bits per low latch bit
    logic [1:0] mem_size;   // 0:64/64 1:128/64 2:128/128
    logic [3:0] pair_ram;   // expansion socket pair is ram
  } hbsi_strap_s;

  typedef struct packed {
    logic [15:0] adr;
    logic [7:0] dat;
    logic iowc;             // i/o write command, active high here
  } hbsi_host_s;

  typedef enum logic [1:0] {HBSI_IDLE, HBSI_OWN, HBSI_REL} hbsi_arb_e;

endpackage : hbsi_pkg

// ===== rtl/hbsi_low_bit.sv
// file: one low command latch bit source selector
`timescale 1ns/10ps
module hbsi_low_bit
  import hbsi_pkg::*;
(
  // select and data
  input wire logic [1:0] src,
  input wire logic din,
  // chosen value
  output logic dout
);

  // unfitted strap pulls high, so unknown codes also give one
  always_comb
  begin
    case (src)
      HBSI_SRC_ZERO: dout = 1'b0;
      HBSI_SRC_DATA: dout = din;
      default: dout = 1'b1;
    endcase
  end

endmodule : hbsi_low_bit

// ===== verif/hbsi_host_model.sv
// host processor board model driving the slave port of the block
`timescale 1ns/10ps
module hbsi_host_model
  import hbsi_pkg::*;
(
  // clock
  input wire logic clk,
  // system bus side
  output hbsi_host_s host,
  output logic cbrq_in_n
);
  // ---------------------------------------------------------------
  // idle bus
  // ---------------------------------------------------------------
  initial
  begin
    host.adr = 16'hFFFF;
    host.dat = 8'hFF;
    host.iowc = 1'b0;
    cbrq_in_n = 1'b1;
  end

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // one i/o write, entered just after an edge; a released bus shows the
  // inverse so that a stale address or data byte can never pass
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    host.adr = a;
    host.dat = d;
    host.iowc = 1'b1;
    @(posedge clk);
    #1;
    host.iowc = 1'b0;
    host.adr = ~a;
    host.dat = ~d;
  endtask : io_write

  // another requester asking for the bus, active low
  task automatic rival(input logic n);
    cbrq_in_n = n;
  endtask : rival
endmodule : hbsi_host_model

// ===== verif/host_bus_strap_interface_test.sv
// self-checking bench for the host bus strap interface
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module host_bus_strap_interface_test;
  import hbsi_pkg::*;
  logic clk, rst, bus_req, cycle_done, cpu_wait_idle, bpro_arb_n;
  logic host_irq_req, cycle_start, ext_ready, ram_access, tx_clk;
  logic cbrq_in_n, own, cbo, cba, bpo, bclk, cclk, rdy, tirq, roms, rams;
  logic [17:0] local_adr;
  logic [7:0] hi, mid, lo, bint, e_hi, e_mid, e_lo;
  logic [15:0] a;
  logic [2:0] flag;
  hbsi_strap_s strap;
  hbsi_host_s host;
  int fails, total_checks, seed, n;

  // ---------------------------------------------------------------
  // partner and design
  // ---------------------------------------------------------------
  hbsi_host_model p (.clk(clk), .host(host), .cbrq_in_n(cbrq_in_n));
  hbsi_top dut (.clk(clk), .rst(rst), .strap(strap), .host(host),
    .bus_req(bus_req), .cbrq_in_n(cbrq_in_n), .cycle_done(cycle_done),
    .cpu_wait_idle(cpu_wait_idle), .bpro_arb_n(bpro_arb_n),
    .host_irq_req(host_irq_req), .cycle_start(cycle_start),
    .ext_ready(ext_ready), .ram_access(ram_access), .local_adr(local_adr),
    .tx_clk(tx_clk), .host_command_high(hi), .host_command_mid(mid),
    .host_command_low(lo), .flag_pulse(flag), .bus_int(bint),
    .bus_owned(own), .cbrq_out_n(cbo), .cbrq_arb_n(cba), .bpro_out_n(bpo),
    .bclk_out(bclk), .cclk_out_n(cclk), .local_ready(rdy), .tmo_irq(tirq),
    .rom_sel(roms), .ram_sel(rams));

  // ---------------------------------------------------------------
  // clocks
  // ---------------------------------------------------------------
  // tx_clk is 10 MHz and runs free, unrelated in phase to clk
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    tx_clk = 1'b0;
    #7;
    forever #50 tx_clk = ~tx_clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  // expected low latch byte from the per-bit source selects
  function automatic logic [7:0] low_exp(logic [15:0] s, logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = s[2*i +: 2] == HBSI_SRC_DATA ? v[i] :
        (s[2*i +: 2] == HBSI_SRC_ZERO ? 1'b0 : 1'b1);
    end
    return r;
  endfunction : low_exp

  // expected rom select of one 32K bank under the chosen memory map
  function automatic logic rom_exp(logic [2:0] b, hbsi_strap_s s);
    logic r;
    r = s.mem_size == 2'h1;
    if (b == 3'h7)
      r = 1'b1;
    else if (b == 3'h0)
      r = 1'b0;
    else if (b >= 3'h3)
      r = !s.pair_ram[b - 3'h3];
    return r;
  endfunction : rom_exp

  // write through the partner, update the model, compare all latches
  task automatic wr(input logic [15:0] adr, input logic [7:0] v);
    logic h;
    logic [2:0] ef;
    h = ((adr ^ strap.base) & (strap.addr16 ? 16'hFFFC : 16'h00FC)) == 0;
    p.io_write(adr, v);
    // the flag port pulses for one cycle only, so look just after the edge
    ef = (h && adr[1:0] == HBSI_OFS_FLAG) ? v[2:0] : 3'h0;
    `CHK(flag, ef)
    if (h && adr[1:0] == HBSI_OFS_LOW) e_lo = low_exp(strap.low_src, v);
    if (h && adr[1:0] == HBSI_OFS_MID) e_mid = v;
    if (h && adr[1:0] == HBSI_OFS_HIGH) e_hi = v;
    tick(1);
    `CHK(lo, e_lo)
    `CHK(mid, e_mid)
    `CHK(hi, e_hi)
  endtask : wr

  // take the bus, then let a rival ask for it at the end of a cycle
  task automatic arb(input logic hold);
    strap.bus_hold = hold;
    bus_req = 1'b1;
    tick(2);
    `CHK(own, 1'b1)
    `CHK(bclk, ~cclk)
    `CHK(bclk, tx_clk)
    bus_req = 1'b0;
    p.rival(1'b0);
    cycle_done = 1'b1;
    tick(1);
    cycle_done = 1'b0;
    tick(1);
    `CHK(own, hold)
    cpu_wait_idle = 1'b1;
    tick(2);
    `CHK(own, 1'b0)
    `CHK(bclk, 1'b0)
    cpu_wait_idle = 0;
    p.rival(1'b1);
    tick(2);
  endtask : arb

  // one local cycle: 0 zero wait, 1 one wait, 2 external, 3 timeout
  // e counts edges after the start edge up to ready: one plus the waits
  task automatic rd(input int m, input int e);
    ram_access = m < 2;
    cycle_start = 1'b1;
    tick(1);
    cycle_start = 1'b0;
    ext_ready = m == 2;
    n = 0;
    do
    begin
      tick(1);
      n++;
    end
    while (n < 8 && rdy !== 1'b1);
    if (m == 3)
      `CHK(n <= e, 1'b1)
    else
      `CHK(n, e)
    `CHK(tirq, m == 3 && strap.tmo_int_en)
    ram_access = 1'b0;
    ext_ready = 1'b0;
    tick(2);
  endtask : rd

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    #100000;
    fails++;
    close_out();
  end

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    seed = 72;
    fails = 0;
    total_checks = 0;
    rst = 1'b1;
    {bus_req, cycle_done, cpu_wait_idle, host_irq_req} = 4'h0;
    {cycle_start, ext_ready, ram_access, bpro_arb_n} = 4'h1;
    local_adr = 18'h00000;
    strap = '0;
    strap.base = HBSI_BASE_DEFAULT;
    strap.int_sel = HBSI_INT_SEL_DEFAULT;
    strap.req_to_bus = 1'b1;
    strap.clk_opt = 1'b1;
    {e_hi, e_mid, e_lo} = {3{HBSI_LATCH_RESET}};
    tick(10);
    rst = 1'b0;
    `CHK(lo, HBSI_LATCH_RESET)
    `CHK(cbo, 1'b1)
    $display("reset test done");
    wr(HBSI_BASE_DEFAULT | 16'h0001, 8'h00);
    for (int i = 0; i < 40; i++)
    begin
      n = $random(seed);
      strap.low_src = n[15:0] & ~((n[15:0] & 16'h5555) << 1);
      a = {n[31:24], strap.base[7:2], n[17:16]};
      if (n[20]) a[2 + n[23:21] % 6] ^= 1'b1;
      wr(a, 8'($random(seed)));
    end
    strap.addr16 = 1'b1;
    strap.base = 16'hD5AC;
    wr(16'h00AF, 8'h5A);
    wr(16'hD5AF, 8'hA5);
    wr(16'hD5AE, 8'h3C);
    $display("latch test done");
    host_irq_req = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      strap.int_sel = i[2:0];
      tick(3);
      `CHK(bint, 8'h01 << i)
    end
    host_irq_req = 1'b0;
    $display("interrupt test done");
    arb(1'b0);
    arb(1'b1);
    strap.req_to_bus = 1'b0;
    bpro_arb_n = 1'b0;
    tick(3);
    `CHK(cba, 1'b0)
    `CHK(bpo, 1'b0)
    $display("arbitration test done");
    strap.zero_wait = 1'b1;
    rd(0, 1);
    strap.zero_wait = 1'b0;
    rd(1, 2);
    rd(2, 1);
    strap.tmo_en = 1'b1;
    strap.tmo_int_en = 1'b1;
    rd(3, HBSI_TIMEOUT_CYC);
    strap.tmo_int_en = 1'b0;
    rd(3, HBSI_TIMEOUT_CYC);
    $display("ready test done");
    local_adr = 18'h3FFFF;
    tick(3);
    `CHK(roms, 1'b1)
    local_adr = 18'h00000;
    tick(3);
    `CHK(rams, 1'b1)
    // random socket pair types and size code, every bank visited
    n = $random(seed);
    strap.pair_ram = n[3:0];
    strap.mem_size = (n[5:4] == 2'h3) ? 2'h1 : n[5:4];
    for (int i = 0; i < 8; i++)
    begin
      local_adr = {i[2:0], 15'h0000};
      tick(2);
      `CHK(roms, rom_exp(i[2:0], strap))
      `CHK(rams, !rom_exp(i[2:0], strap))
    end
    $display("memory test done");
    close_out();
  end
endmodule : host_bus_strap_interface_test
